// file: rtl/lpwc_ctrl.v
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "lpwc_defs.vh"

module lpwc_ctrl (
   input  wire                     pclk,
   input  wire                     presetn,
   input  wire                     psel,
   input  wire                     penable,
   input  wire                     pwrite,
   input  wire [11:0]              paddr,
   input  wire [31:0]              pwdata,
   output reg  [31:0]              prdata_ff,
   output reg                      pready_ff,
   output reg                      pslverr_ff,
   input  wire                     core_wfi,
   input  wire                     core_last_return,
   input  wire                     core_in_handler,
   input  wire [1:0]               core_active_prio,
   input  wire [`LPWC_NSRC-1:0]    core_vector_set,
   input  wire [`LPWC_NSRC-1:0]    irq_pending,
   input  wire                     clk_ready,
   input  wire                     supply_monitor_reset,
   input  wire                     external_reset_pin_n,
   input  wire                     low_voltage_reset,
   input  wire                     independent_watchdog_reset,
   input  wire                     window_watchdog_reset,
   input  wire                     core_stall_fault,
   input  wire                     software_reset_request,
   output reg                      core_halt_ff,
   output reg                      wake_req_ff,
   output reg                      resume_valid_ff,
   output reg  [1:0]               resume_kind_ff,
   output reg  [5:0]               resume_src_ff,
   output reg                      sys_reset_ff,
   output reg  [2:0]               system_clock_source_field_src_ff,
   output reg  [2:0]               bus_div_ff,
   output reg  [1:0]               periph_div_ff,
   output reg                      hclk_en_ff,
   output reg                      pclk_en_ff,
   output reg                      int_fast_osc_en_ff,
   output reg                      ext_fast_osc_en_ff,
   output reg                      int_slow_osc_en_ff,
   output reg                      ext_slow_osc_en_ff,
   output reg  [31:0]              fast_bus_clock_gates_ff,
   output reg  [31:0]              periph_clock_gates_one_ff,
   output reg  [31:0]              periph_clock_gates_two_ff
);

   reg  [31:0]                ctrl_ff;
   reg  [31:0]                cfg0_ff;
   reg  [31:0]                wen_lo_ff;
   reg  [10:0]                wen_hi_ff;
   reg  [31:0]                prio0_ff;
   reg  [31:0]                prio1_ff;
   reg  [21:0]                prio2_ff;
   reg  [1:0]                 state_ff;
   reg  [1:0]                 nxt_state;
   reg                        by_return_ff;
   reg                        from_deep_ff;
   reg                        pin_s1_ff;
   reg                        pin_s2_ff;
   reg                        pin_s3_ff;
   reg                        pin_level_ff;
   reg  [31:0]                nxt_rdata;
   reg                        addr_ok;

   wire                       wake_any;
   wire [5:0]                 wake_idx;
   wire                       acc     = psel & penable & ~pready_ff;
   wire                       wr_done = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   wire                       sleeping = (state_ff == `LPWC_ST_SLEEP) || (state_ff == `LPWC_ST_DEEP);
   wire                       enter   = core_wfi | (core_last_return & ctrl_ff[`LPWC_CTRL_RETSLP]);
   wire                       wake_clk_sel = ctrl_ff[`LPWC_CTRL_WAKECLK];

   // Eligibility is judged for the mode of the coming cycle, so DeepSleep entry never wakes on a stale source
   lpwc_wake_sel u_wake_sel (
      .pclk        (pclk),
      .presetn     (presetn),
      .pend        (irq_pending),
      .enable      ({wen_hi_ff, wen_lo_ff}),
      .prio        ({prio2_ff, prio1_ff, prio0_ff}),
      .deep        (nxt_state == `LPWC_ST_DEEP),
      .in_handler  (core_in_handler & ~by_return_ff),
      .act_prio    (core_active_prio),
      .wake_any_ff (wake_any),
      .wake_idx_ff (wake_idx)
   );

   // APB: one wait state, so read data and error come out of flops
   always @* begin
      addr_ok   = 1'b1;
      nxt_rdata = 32'h0000_0000;
      case (paddr)
         `LPWC_OFS_CTRL:      nxt_rdata = ctrl_ff;
         `LPWC_OFS_CFG0:      nxt_rdata = cfg0_ff;
         `LPWC_OFS_GATE_FAST: nxt_rdata = fast_bus_clock_gates_ff;
         `LPWC_OFS_GATE_PER1: nxt_rdata = periph_clock_gates_one_ff;
         `LPWC_OFS_GATE_PER2: nxt_rdata = periph_clock_gates_two_ff;
         `LPWC_OFS_WEN_LO:    nxt_rdata = wen_lo_ff;
         `LPWC_OFS_WEN_HI:    nxt_rdata = {21'h00_0000, wen_hi_ff};
         `LPWC_OFS_PRIO0:     nxt_rdata = prio0_ff;
         `LPWC_OFS_PRIO1:     nxt_rdata = prio1_ff;
         `LPWC_OFS_PRIO2:     nxt_rdata = {10'h000, prio2_ff};
         `LPWC_OFS_STATUS:    nxt_rdata = {15'h0000, pin_level_ff, 2'h0, resume_src_ff, 2'h0,
                                           resume_kind_ff, 1'b0, wake_req_ff, state_ff};
         default:             addr_ok = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= acc;
         pslverr_ff <= acc & ~addr_ok;
         if (acc && !pwrite) begin
            prdata_ff <= nxt_rdata;
         end
      end
   end

   // Software-owned registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff                   <= `LPWC_CTRL_RESET;
         wen_lo_ff                 <= 32'h0000_0000;
         wen_hi_ff                 <= 11'h000;
         prio0_ff                  <= `LPWC_PRIO_RESET;
         prio1_ff                  <= `LPWC_PRIO_RESET;
         prio2_ff                  <= 22'h00_0000;
         fast_bus_clock_gates_ff   <= 32'h0000_0000;
         periph_clock_gates_one_ff <= 32'h0000_0000;
         periph_clock_gates_two_ff <= 32'h0000_0000;
      end else if (wr_done) begin
         case (paddr)
            `LPWC_OFS_CTRL:      ctrl_ff <= {28'h000_0000, pwdata[3:0]};
            `LPWC_OFS_GATE_FAST: fast_bus_clock_gates_ff <= pwdata;
            `LPWC_OFS_GATE_PER1: periph_clock_gates_one_ff <= pwdata;
            `LPWC_OFS_GATE_PER2: periph_clock_gates_two_ff <= pwdata;
            `LPWC_OFS_WEN_LO:    wen_lo_ff <= pwdata;
            `LPWC_OFS_WEN_HI:    wen_hi_ff <= pwdata[10:0];
            `LPWC_OFS_PRIO0:     prio0_ff <= pwdata;
            `LPWC_OFS_PRIO1:     prio1_ff <= pwdata;
            `LPWC_OFS_PRIO2:     prio2_ff <= pwdata[21:0];
            default:             ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // Clock configuration; the wake path may rewrite the source field
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg0_ff <= `LPWC_CFG_RESET;
      end else if (state_ff == `LPWC_ST_DEEP && wake_any && wake_clk_sel) begin
         cfg0_ff[`LPWC_CFG_SRC_LSB+2:`LPWC_CFG_SRC_LSB] <= `LPWC_SRC_IFOSC;
         cfg0_ff[`LPWC_CFG_IFOSC_EN]                    <= 1'b1;
      end else if (wr_done && paddr == `LPWC_OFS_CFG0) begin
         cfg0_ff <= {12'h000, pwdata[19:16], 2'h0, pwdata[13:12], 2'h0, pwdata[9:8],
                     1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_clock_source_field_src_ff      <= `LPWC_SRC_IFOSC;
         bus_div_ff         <= 3'h0;
         periph_div_ff      <= 2'h0;
         hclk_en_ff         <= 1'b1;
         pclk_en_ff         <= 1'b1;
         int_fast_osc_en_ff <= 1'b1;
         ext_fast_osc_en_ff <= 1'b0;
         int_slow_osc_en_ff <= 1'b0;
         ext_slow_osc_en_ff <= 1'b0;
      end else begin
         system_clock_source_field_src_ff      <= cfg0_ff[`LPWC_CFG_SRC_LSB+2:`LPWC_CFG_SRC_LSB];
         bus_div_ff         <= cfg0_ff[`LPWC_CFG_BDIV_LSB+2:`LPWC_CFG_BDIV_LSB];
         periph_div_ff      <= cfg0_ff[`LPWC_CFG_PDIV_LSB+1:`LPWC_CFG_PDIV_LSB];
         // Sleep leaves bus clocks as programmed so peripherals keep running
         hclk_en_ff         <= cfg0_ff[`LPWC_CFG_HCLK_EN];
         pclk_en_ff         <= cfg0_ff[`LPWC_CFG_PCLK_EN];
         int_fast_osc_en_ff <= cfg0_ff[`LPWC_CFG_IFOSC_EN] & (state_ff != `LPWC_ST_DEEP);
         ext_fast_osc_en_ff <= cfg0_ff[`LPWC_CFG_EFOSC_EN] & (state_ff != `LPWC_ST_DEEP);
         int_slow_osc_en_ff <= cfg0_ff[`LPWC_CFG_ISOSC_EN];
         ext_slow_osc_en_ff <= cfg0_ff[`LPWC_CFG_ESOSC_EN];
      end
   end

   // Mode sequencer
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `LPWC_ST_ACTIVE: begin
            if (enter) begin
               nxt_state = ctrl_ff[`LPWC_CTRL_DEEP] ? `LPWC_ST_DEEP : `LPWC_ST_SLEEP;
            end
         end
         `LPWC_ST_SLEEP: begin
            if (wake_any) begin
               nxt_state = `LPWC_ST_WAKE;
            end
         end
         `LPWC_ST_DEEP: begin
            if (wake_any) begin
               nxt_state = `LPWC_ST_WAKE;
            end
         end
         `LPWC_ST_WAKE: begin
            // Fast oscillators must be back before the core restarts
            if (clk_ready) begin
               nxt_state = `LPWC_ST_ACTIVE;
            end
         end
         default: nxt_state = `LPWC_ST_ACTIVE;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff        <= `LPWC_ST_ACTIVE;
         by_return_ff    <= 1'b0;
         from_deep_ff    <= 1'b0;
         core_halt_ff    <= 1'b0;
         wake_req_ff     <= 1'b0;
         resume_valid_ff <= 1'b0;
         resume_kind_ff  <= `LPWC_RES_ISR;
         resume_src_ff   <= 6'h00;
      end else begin
         state_ff        <= nxt_state;
         core_halt_ff    <= (nxt_state != `LPWC_ST_ACTIVE);
         resume_valid_ff <= (state_ff == `LPWC_ST_WAKE) && clk_ready;
         if (state_ff == `LPWC_ST_ACTIVE && enter) begin
            by_return_ff <= ~core_wfi;
            from_deep_ff <= ctrl_ff[`LPWC_CTRL_DEEP];
         end
         if (sleeping && wake_any) begin
            wake_req_ff   <= 1'b1;
            resume_src_ff <= wake_idx;
            // Same resume decision for Sleep and DeepSleep exits
            if (core_vector_set[wake_idx]) begin
               resume_kind_ff <= `LPWC_RES_ISR;
            end else if (!by_return_ff) begin
               resume_kind_ff <= `LPWC_RES_AFTER_WFI;
            end else begin
               resume_kind_ff <= `LPWC_RES_AFTER_HNDL;
            end
         end else if (state_ff == `LPWC_ST_WAKE && clk_ready) begin
            wake_req_ff <= 1'b0;
         end
      end
   end

   // Reset pin: three stages, a change counts once stages two and three agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_ff    <= 1'b1;
         pin_s2_ff    <= 1'b1;
         pin_s3_ff    <= 1'b1;
         pin_level_ff <= 1'b1;
      end else begin
         pin_s1_ff <= external_reset_pin_n;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         if (pin_s2_ff == pin_s3_ff) begin
            pin_level_ff <= pin_s3_ff;
         end
      end
   end

   // Core stall reset also needs its enable; it was off out of power-up
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_ff <= 1'b0;
      end else begin
         sys_reset_ff <= supply_monitor_reset | ~pin_level_ff | low_voltage_reset
                         | independent_watchdog_reset
                         | (window_watchdog_reset & (state_ff != `LPWC_ST_DEEP))
                         | ((state_ff == `LPWC_ST_ACTIVE)
                            & ((core_stall_fault & ctrl_ff[`LPWC_CTRL_STALLEN])
                               | software_reset_request));
      end
   end

endmodule

// file: inc/lpwc_defs.vh
`ifndef LPWC_DEFS_VH
`define LPWC_DEFS_VH

// Register byte offsets
`define LPWC_OFS_CTRL        12'h000
`define LPWC_OFS_CFG0        12'h004
`define LPWC_OFS_GATE_FAST   12'h008
`define LPWC_OFS_GATE_PER1   12'h00C
`define LPWC_OFS_GATE_PER2   12'h010
`define LPWC_OFS_WEN_LO      12'h014
`define LPWC_OFS_WEN_HI      12'h018
`define LPWC_OFS_PRIO0       12'h01C
`define LPWC_OFS_PRIO1       12'h020
`define LPWC_OFS_PRIO2       12'h024
`define LPWC_OFS_STATUS      12'h028

// Control register fields
`define LPWC_CTRL_DEEP       0
`define LPWC_CTRL_RETSLP     1
`define LPWC_CTRL_WAKECLK    2
`define LPWC_CTRL_STALLEN    3
`define LPWC_CTRL_RESET      32'h0000_0000

// Clock config register fields
`define LPWC_CFG_SRC_LSB     0
`define LPWC_CFG_BDIV_LSB    4
`define LPWC_CFG_PDIV_LSB    8
`define LPWC_CFG_HCLK_EN     12
`define LPWC_CFG_PCLK_EN     13
`define LPWC_CFG_IFOSC_EN    16
`define LPWC_CFG_EFOSC_EN    17
`define LPWC_CFG_ISOSC_EN    18
`define LPWC_CFG_ESOSC_EN    19
`define LPWC_CFG_RESET       32'h0001_3000
`define LPWC_SRC_IFOSC       3'h0

// Wake sources: 43 lines, fixed order (see hand-over)
`define LPWC_NSRC            43
`define LPWC_DEEP_OK         43'h7FC_2030_1FCD
`define LPWC_PRIO_RESET      32'h0000_0000

// Mode states
`define LPWC_ST_ACTIVE       2'h0
`define LPWC_ST_SLEEP        2'h1
`define LPWC_ST_DEEP         2'h2
`define LPWC_ST_WAKE         2'h3

// Resume kinds
`define LPWC_RES_ISR         2'h0
`define LPWC_RES_AFTER_WFI   2'h1
`define LPWC_RES_AFTER_HNDL  2'h2

`endif

// file: rtl/lpwc_wake_sel.v
`timescale 1ns/1ps
`include "lpwc_defs.vh"

module lpwc_wake_sel (
   input  wire                      pclk,
   input  wire                      presetn,
   input  wire [`LPWC_NSRC-1:0]     pend,
   input  wire [`LPWC_NSRC-1:0]     enable,
   input  wire [2*`LPWC_NSRC-1:0]   prio,
   input  wire                      deep,
   input  wire                      in_handler,
   input  wire [1:0]                act_prio,
   output reg                       wake_any_ff,
   output reg  [5:0]                wake_idx_ff
);

   // A literal cannot be bit-selected, so the deep-capable mask is held as a constant vector
   localparam [`LPWC_NSRC-1:0] deep_ok_mask = `LPWC_DEEP_OK;

   wire [`LPWC_NSRC-1:0] elig;
   reg  [5:0]            nxt_idx;
   integer               i;

   genvar g;
   generate
      for (g = 0; g < `LPWC_NSRC; g = g + 1) begin : g_src
         // Lower value is more urgent; inside a handler only a strictly more urgent line may wake
         wire prio_ok = !in_handler || (prio[2*g+1:2*g] < act_prio);
         wire mode_ok = !deep || deep_ok_mask[g];
         assign elig[g] = pend[g] & enable[g] & mode_ok & prio_ok;
      end
   endgenerate

   always @* begin
      nxt_idx = 6'h00;
      for (i = `LPWC_NSRC - 1; i >= 0; i = i - 1) begin
         if (elig[i]) begin
            nxt_idx = i[5:0];
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_any_ff <= 1'b0;
         wake_idx_ff <= 6'h00;
      end else begin
         wake_any_ff <= |elig;
         wake_idx_ff <= nxt_idx;
      end
   end

endmodule

// file: bench/lpwc_props.sv
`timescale 1ns/1ps
module lpwc_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready_ff,
   input wire logic core_wfi,
   input wire logic core_last_return,
   input wire logic clk_ready,
   input wire logic core_halt_ff,
   input wire logic wake_req_ff,
   input wire logic resume_valid_ff,
   input wire logic sys_reset_ff,
   input wire logic supply_monitor_reset,
   input wire logic external_reset_pin_n,
   input wire logic low_voltage_reset,
   input wire logic independent_watchdog_reset,
   input wire logic window_watchdog_reset,
   input wire logic core_stall_fault,
   input wire logic software_reset_request
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_pready; psel && penable && !pready_ff |=> pready_ff; endproperty
   a_pready: assert property (p_pready) else $error("ready missing after one wait state");
   property p_halt; !core_halt_ff && !wake_req_ff && core_wfi |-> ##[1:2] core_halt_ff; endproperty
   a_halt: assert property (p_halt) else $error("core not halted after wait instruction");
   property p_held; wake_req_ff && !clk_ready |=> wake_req_ff; endproperty
   a_held: assert property (p_held) else $error("wake request dropped before clock ready");
   property p_resume; wake_req_ff && clk_ready |=> !wake_req_ff && !core_halt_ff; endproperty
   a_resume: assert property (p_resume) else $error("core not released once clock ready");
   property p_valid; $fell(core_halt_ff) |-> ##[0:1] resume_valid_ff; endproperty
   a_valid: assert property (p_valid) else $error("no resume strobe on release");
   property p_idle; !core_halt_ff |-> !wake_req_ff; endproperty
   a_idle: assert property (p_idle) else $error("wake request while core runs");
   property p_supply; supply_monitor_reset |=> sys_reset_ff; endproperty
   a_supply: assert property (p_supply) else $error("supply reset not passed on");
   property p_wdg_lv; independent_watchdog_reset || low_voltage_reset |=> sys_reset_ff; endproperty
   a_wdg_lv: assert property (p_wdg_lv) else $error("watchdog or low voltage reset lost");
   property p_pin; !external_reset_pin_n [*6] |-> sys_reset_ff; endproperty
   a_pin: assert property (p_pin) else $error("pin reset not passed on");
   property p_win;
      window_watchdog_reset && !core_halt_ff && !$past(core_wfi) && !$past(core_last_return) |=> sys_reset_ff;
   endproperty
   a_win: assert property (p_win) else $error("window watchdog reset lost while active");
   property p_soft;
      core_halt_ff && (software_reset_request || core_stall_fault) && !supply_monitor_reset && !low_voltage_reset
      && !independent_watchdog_reset && !window_watchdog_reset && external_reset_pin_n
      && $past(external_reset_pin_n, 5) |=> !sys_reset_ff;
   endproperty
   a_soft: assert property (p_soft) else $error("core reset request honoured while halted");
endmodule

bind lpwc_ctrl lpwc_props u_props (.pclk, .presetn, .psel, .penable, .pready_ff, .core_wfi, .core_last_return,
   .clk_ready, .core_halt_ff, .wake_req_ff, .resume_valid_ff, .sys_reset_ff, .supply_monitor_reset,
   .external_reset_pin_n, .low_voltage_reset, .independent_watchdog_reset, .window_watchdog_reset,
   .core_stall_fault, .software_reset_request);

// file: bench/lpwc_core_model.sv
`timescale 1ns/1ps
module lpwc_core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       core_halt_ff,
   input  wire logic       wake_req_ff,
   input  wire logic [2:0] lat,
   output logic            clk_ready
);
   logic [2:0] cnt_ff;
   // Clock reads unstable while halted, so a wake can never finish early
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 3'h0;
         clk_ready <= 1'h1;
      end else if (wake_req_ff && cnt_ff >= lat) begin
         clk_ready <= 1'h1;
      end else if (wake_req_ff) begin
         cnt_ff <= cnt_ff + 3'h1;
         clk_ready <= 1'h0;
      end else begin
         cnt_ff <= 3'h0;
         clk_ready <= !core_halt_ff;
      end
   end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
`include "lpwc_defs.vh"
module tb;
   localparam logic [`LPWC_NSRC-1:0] deep_ok = `LPWC_DEEP_OK;
   logic                  pclk, presetn, psel, penable, pwrite, core_wfi, core_last_return, core_in_handler, er, dp, wk;
   logic [11:0]           paddr;
   logic [31:0]           pwdata, rd, cfg;
   logic [95:0]           gv;
   logic [1:0]            core_active_prio;
   logic [`LPWC_NSRC-1:0] core_vector_set, irq_pending, en;
   logic [6:0]            rst_v;
   logic [2:0]            lat;
   wire                   clk_ready, pready_ff, pslverr_ff, core_halt_ff, wake_req_ff, resume_valid_ff, sys_reset_ff;
   wire                   hclk_en_ff, pclk_en_ff, int_fast_osc_en_ff, ext_fast_osc_en_ff, int_slow_osc_en_ff;
   wire                   ext_slow_osc_en_ff;
   wire [31:0]            prdata_ff, fast_bus_clock_gates_ff, periph_clock_gates_one_ff, periph_clock_gates_two_ff;
   wire [1:0]             resume_kind_ff, periph_div_ff;
   wire [5:0]             resume_src_ff;
   wire [2:0]             system_clock_source_field_src_ff, bus_div_ff;
   integer                seed = 5222, errors = 0, cmp_count = 0, i, s, m;
   lpwc_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff, .pslverr_ff,
      .core_wfi, .core_last_return, .core_in_handler, .core_active_prio, .core_vector_set, .irq_pending, .clk_ready,
      .supply_monitor_reset(rst_v[0]), .external_reset_pin_n(~rst_v[1]), .low_voltage_reset(rst_v[2]),
      .independent_watchdog_reset(rst_v[3]), .window_watchdog_reset(rst_v[4]), .core_stall_fault(rst_v[5]),
      .software_reset_request(rst_v[6]), .core_halt_ff, .wake_req_ff, .resume_valid_ff, .resume_kind_ff,
      .resume_src_ff, .sys_reset_ff, .system_clock_source_field_src_ff, .bus_div_ff, .periph_div_ff, .hclk_en_ff, .pclk_en_ff,
      .int_fast_osc_en_ff, .ext_fast_osc_en_ff, .int_slow_osc_en_ff, .ext_slow_osc_en_ff, .fast_bus_clock_gates_ff,
      .periph_clock_gates_one_ff, .periph_clock_gates_two_ff);
   lpwc_core_model i_core (.pclk, .presetn, .core_halt_ff, .wake_req_ff, .lat, .clk_ready);
   initial begin
      pclk = 1'h0;
      forever #2 pclk = ~pclk;
   end
   function logic exp_rst(input integer md, input integer sr);
      logic [6:0] k;
      k = (md == 0) ? 7'h7F : (md == 1) ? 7'h1F : (md == 2) ? 7'h0F : 7'h5F;
      return k[sr];
   endfunction
   task chk(input string nm, input logic [95:0] e, input logic [95:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task do_reset;
      presetn <= 1'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      integer n;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_ff !== 1'h1 && n < 20);
      if (pready_ff !== 1'h1) begin
         errors++;
         end_sim;
      end
      rd = prdata_ff;
      er = pslverr_ff;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task pulse(input logic ret);
      core_wfi <= !ret;
      core_last_return <= ret;
      @(posedge pclk);
      core_wfi <= 1'h0;
      core_last_return <= 1'h0;
      @(posedge pclk);
   endtask
   task expect_wake(input logic ex, input logic [1:0] kind, input logic [5:0] src);
      integer n;
      n = 0;
      while (resume_valid_ff !== 1'h1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      if (ex && resume_valid_ff !== 1'h1) begin
         errors++;
         end_sim;
      end
      if (ex) chk("resume", {kind, src}, {resume_kind_ff, resume_src_ff});
      else chk("stay_halted", 2'h2, {core_halt_ff, resume_valid_ff});
   endtask
   initial begin
      {presetn, psel, penable, pwrite, core_wfi, core_last_return, core_in_handler} = 7'h00;
      {paddr, pwdata, core_active_prio, core_vector_set, irq_pending, rst_v, lat} = '0;
      do_reset;
      chk("out_rst", 6'h38, {hclk_en_ff, pclk_en_ff, int_fast_osc_en_ff, system_clock_source_field_src_ff});
      apb(1'h0, `LPWC_OFS_CFG0, 32'h0000_0000);
      chk("cfg0", 32'h0001_3000, rd);
      apb(1'h0, 12'h02C, 32'h0000_0000);
      chk("unmapped", 33'h1_0000_0000, {er, rd});
      for (i = 0; i < 3; i++) begin
         gv[32*i +: 32] = $random(seed);
         apb(1'h1, 12'(`LPWC_OFS_GATE_FAST + 4 * i), gv[32*i +: 32]);
      end
      chk("gates", gv, {periph_clock_gates_two_ff, periph_clock_gates_one_ff, fast_bus_clock_gates_ff});
      $display("test registers done");
      for (i = 0; i < 2 * `LPWC_NSRC; i++) begin
         s = i % `LPWC_NSRC;
         dp = (i >= `LPWC_NSRC);
         wk = 1'($random(seed));
         lat <= 3'($random(seed));
         cfg = $random(seed) & 32'h000F_3377;
         core_vector_set <= `LPWC_NSRC'({$random(seed), $random(seed)});
         irq_pending <= '0;
         en = `LPWC_NSRC'(1) << s;
         do_reset;
         apb(1'h1, `LPWC_OFS_CFG0, cfg);
         @(posedge pclk);
         chk("clk_cfg", {cfg[2:0], cfg[6:4], cfg[9:8], cfg[13:12]}, {system_clock_source_field_src_ff, bus_div_ff, periph_div_ff,
            pclk_en_ff, hclk_en_ff});
         apb(1'h1, `LPWC_OFS_WEN_LO, en[31:0]);
         apb(1'h1, `LPWC_OFS_WEN_HI, {21'h00_0000, en[42:32]});
         apb(1'h1, `LPWC_OFS_CTRL, {29'h0000_0000, wk, 1'h0, dp});
         pulse(1'h0);
         repeat (3) @(posedge pclk);
         chk("osc", {1'h1, !dp & cfg[16], !dp & cfg[17], cfg[18], cfg[19]}, {core_halt_ff, int_fast_osc_en_ff,
            ext_fast_osc_en_ff, int_slow_osc_en_ff, ext_slow_osc_en_ff});
         irq_pending <= `LPWC_NSRC'(1) << ((s + 1) % `LPWC_NSRC);
         expect_wake(1'h0, 2'h0, 6'h00);
         irq_pending <= en;
         expect_wake(!dp || deep_ok[s], core_vector_set[s] ? `LPWC_RES_ISR : `LPWC_RES_AFTER_WFI,
            6'(s));
         if (dp && deep_ok[s]) chk("wake_clk", wk ? 3'h0 : cfg[2:0], system_clock_source_field_src_ff);
         if (dp && deep_ok[s]) chk("wake_osc", {wk | cfg[16], cfg[17]}, {int_fast_osc_en_ff,
            ext_fast_osc_en_ff});
      end
      $display("test wake sources done");
      irq_pending <= '0;
      core_vector_set <= '0;
      lat <= 3'h7;
      do_reset;
      apb(1'h1, `LPWC_OFS_WEN_LO, 32'h0000_0008);
      apb(1'h1, `LPWC_OFS_PRIO0, 32'h0000_0040);
      core_in_handler <= 1'h1;
      core_active_prio <= 2'h1;
      pulse(1'h0);
      irq_pending <= `LPWC_NSRC'(8);
      expect_wake(1'h0, 2'h0, 6'h00);
      apb(1'h1, `LPWC_OFS_PRIO0, 32'h0000_0000);
      expect_wake(1'h1, `LPWC_RES_AFTER_WFI, 6'h03);
      core_in_handler <= 1'h0;
      irq_pending <= '0;
      do_reset;
      apb(1'h1, `LPWC_OFS_WEN_LO, 32'h0000_0001);
      pulse(1'h1);
      chk("no_return_sleep", 1'h0, core_halt_ff);
      apb(1'h1, `LPWC_OFS_CTRL, 32'h0000_0002);
      pulse(1'h1);
      irq_pending <= `LPWC_NSRC'(1);
      expect_wake(1'h1, `LPWC_RES_AFTER_HNDL, 6'h00);
      irq_pending <= '0;
      $display("test priority and return done");
      for (m = 0; m < 4; m++) begin
         for (s = 0; s < 7; s++) begin
            do_reset;
            apb(1'h1, `LPWC_OFS_CTRL, {28'h000_0000, m != 3, 2'h0, m == 2});
            if (m == 1 || m == 2) pulse(1'h0);
            rst_v[s] <= 1'h1;
            repeat (8) @(posedge pclk);
            chk("sys_reset", exp_rst(m, s), sys_reset_ff);
            rst_v <= 7'h00;
         end
      end
      $display("test reset sources done");
      end_sim;
   end
endmodule
